// ### rtl/sfs_top.sv
// FIFO status flags, DMA requests and register slave of the serial port
//
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
`include "sfs_defines.svh"

module sfs_top
   import sfs_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // FIFO traffic
   input  wire logic        tx_push_i,
   input  wire logic        tx_pop_i,
   input  wire logic        rx_push_i,
   input  wire logic        data_high_read_i,
   input  wire logic        data_low_read_i,
   output logic             rx_pop_o,
   output logic             fifo_flush_o,
   // Flags and requests
   output sfs_flags_t       flags_o,
   output logic             tx_dma_req_o,
   output logic             rx_dma_req_o,
   output logic             irq_o
);
   import sfs_pkg::*;

   sfs_bus_state_t bus_state_reg;
   sfs_bus_state_t bus_state_next;
   sfs_ctrl_t      ctrl_reg;
   sfs_ctrl_t      ctrl_next;
   sfs_flags_t     flags_reg;
   sfs_flags_t     flags_next;
   logic [31:0]    rdata_reg;
   logic [31:0]    rdata_next;
   logic           req;
   logic           wr_take;
   logic           sel_ctrl;
   logic           sel_status;
   logic           sel_istat;
   logic           sel_imask;
   logic           settings_flush;
   logic           high_seen_reg;
   logic           rx_pop;
   logic [7:0]     tx_bits;
   logic [7:0]     rx_bits;
   logic [7:0]     rx_nf_limit;
   logic [7:0]     tx_ne_limit;
   logic [3:0]     irq_events;
   logic [3:0]     irq_stat;
   logic [3:0]     irq_mask;
   logic           irq_level;

   sfs_occ_if tx_occ ();
   sfs_occ_if rx_occ ();

   // Bits held for a count of entries at the current width
   function automatic logic [7:0] sfs_fill_bits(input logic [3:0] entries,
                                                 input logic       wide);
      logic [7:0] bits;
      bits = wide ? {entries, 4'h0} : {1'b0, entries, 3'h0};
      return bits;
   endfunction

   // Register address match on the word address
   function automatic logic sfs_hit(input logic [7:0] adr,
                                    input logic [7:0] off);
      logic match;
      match = (adr[7:2] == off[7:2]);
      return match;
   endfunction

   // Request present and not yet answered
   assign req     = wb_cyc_i && wb_stb_i && (bus_state_reg == SFS_BUS_IDLE);
   assign wr_take = req && wb_we_i && wb_sel_i[0];

   // Address decode
   assign sel_ctrl   = sfs_hit(wb_adr_i, `SFS_OFF_CTRL);
   assign sel_status = sfs_hit(wb_adr_i, `SFS_OFF_STATUS);
   assign sel_istat  = sfs_hit(wb_adr_i, `SFS_OFF_IRQ_STAT);
   assign sel_imask  = sfs_hit(wb_adr_i, `SFS_OFF_IRQ_MASK);

   // Bus state: one cycle of ack per request
   always_comb begin
      bus_state_next = bus_state_reg;
      case (bus_state_reg)
         SFS_BUS_IDLE: begin
            if (wb_cyc_i && wb_stb_i) begin
               bus_state_next = SFS_BUS_ACK;
            end
         end
         SFS_BUS_ACK: begin
            bus_state_next = SFS_BUS_IDLE;
         end
         default: begin
            bus_state_next = SFS_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_state_reg <= SFS_BUS_IDLE;
      end else if (ce_i) begin
         bus_state_reg <= bus_state_next;
      end
   end

   assign wb_ack_o = (bus_state_reg == SFS_BUS_ACK);

   // Control register next value from a write
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_take && sel_ctrl) begin
         ctrl_next = sfs_ctrl_t'(wb_dat_i[6:0]);
      end
   end

   // Width, queue mode or enable changed by this write
   assign settings_flush = wr_take && sel_ctrl &&
      ((ctrl_next.word_width_select != ctrl_reg.word_width_select) ||
       (ctrl_next.queue_mode_enable != ctrl_reg.queue_mode_enable) ||
       (ctrl_next.module_enable     != ctrl_reg.module_enable));

   // Control register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= sfs_ctrl_t'(`SFS_CTRL_RST);
      end else if (ce_i) begin
         ctrl_reg <= ctrl_next;
      end
   end

   // Read data, captured with the ack
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (sel_ctrl) begin
         rdata_next[6:0] = ctrl_reg;
      end else if (sel_status) begin
         rdata_next[3:0] = flags_reg;
      end else if (sel_istat) begin
         rdata_next[3:0] = irq_stat;
      end else if (sel_imask) begin
         rdata_next[3:0] = irq_mask;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (ce_i && req) begin
         rdata_reg <= wb_we_i ? 32'h0000_0000 : rdata_next;
      end
   end

   assign wb_dat_o = rdata_reg;

   // Pairing of high and low reads in 16-bit mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         high_seen_reg <= 1'b0;
      end else if (ce_i) begin
         if (settings_flush || data_low_read_i) begin
            high_seen_reg <= 1'b0;
         end else if (data_high_read_i) begin
            high_seen_reg <= 1'b1;
         end
      end
   end

   // Pop on the low read, after the high one when words are 16 bits
   assign rx_pop = ctrl_reg.module_enable && data_low_read_i &&
                   (!ctrl_reg.word_width_select || high_seen_reg || data_high_read_i);

   // Transmit counter hookup
   assign tx_occ.push  = ctrl_reg.module_enable && tx_push_i;
   assign tx_occ.pop   = ctrl_reg.module_enable && tx_pop_i;
   assign tx_occ.flush = settings_flush;
   assign tx_occ.wide  = ctrl_reg.word_width_select;

   // Receive counter hookup
   assign rx_occ.push  = ctrl_reg.module_enable && rx_push_i;
   assign rx_occ.pop   = rx_pop;
   assign rx_occ.flush = settings_flush;
   assign rx_occ.wide  = ctrl_reg.word_width_select;

   sfs_occ_count u_tx_count (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .occ   (tx_occ)
   );

   sfs_occ_count u_rx_count (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .occ   (rx_occ)
   );

   // Occupancy in bits and selected thresholds
   assign tx_bits     = sfs_fill_bits(tx_occ.level, ctrl_reg.word_width_select);
   assign rx_bits     = sfs_fill_bits(rx_occ.level, ctrl_reg.word_width_select);
   assign rx_nf_limit = ctrl_reg.rx_watermark_select ? `SFS_RX_NF_BITS_M1
                                                     : `SFS_RX_NF_BITS_M0;
   assign tx_ne_limit = ctrl_reg.tx_watermark_select ? `SFS_TX_NE_BITS_M1
                                                     : `SFS_TX_NE_BITS_M0;

   // Flag values from occupancy, all zero without queue mode
   always_comb begin
      flags_next = sfs_flags_t'(`SFS_FLAGS_RST);
      if (ctrl_reg.queue_mode_enable) begin
         flags_next.rx_nearly_full_flag  = (rx_bits >= rx_nf_limit);
         flags_next.tx_nearly_empty_flag = (tx_bits <= tx_ne_limit);
         flags_next.tx_full_flag         = (tx_bits >= `SFS_TX_FULL_BITS);
         flags_next.rx_empty_flag        = rx_occ.empty;
      end
   end

   // Flag register: zero at power-on, settings reset follows new queue mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_reg <= sfs_flags_t'(`SFS_FLAGS_RST);
      end else if (ce_i) begin
         if (settings_flush) begin
            flags_reg                      <= sfs_flags_t'(`SFS_FLAGS_RST);
            flags_reg.tx_nearly_empty_flag <= ctrl_next.queue_mode_enable;
            flags_reg.rx_empty_flag        <= ctrl_next.queue_mode_enable;
         end else begin
            flags_reg <= flags_next;
         end
      end
   end

   assign flags_o = flags_reg;

   // DMA requests from inverted full and empty flags
   assign tx_dma_req_o = ctrl_reg.queue_mode_enable && ctrl_reg.tx_dma_enable &&
                         !flags_reg.tx_full_flag;
   assign rx_dma_req_o = ctrl_reg.queue_mode_enable && ctrl_reg.rx_dma_enable &&
                         !flags_reg.rx_empty_flag;

   // Events: nearly-full, nearly-empty and full rising, receive data arriving
   always_comb begin
      irq_events = 4'h0;
      if (!settings_flush) begin
         irq_events[`SFS_ST_RX_NEAR_F] = flags_next.rx_nearly_full_flag &&
                                         !flags_reg.rx_nearly_full_flag;
         irq_events[`SFS_ST_TX_NEAR_E] = flags_next.tx_nearly_empty_flag &&
                                         !flags_reg.tx_nearly_empty_flag;
         irq_events[`SFS_ST_TX_FULL]   = flags_next.tx_full_flag &&
                                         !flags_reg.tx_full_flag;
         irq_events[`SFS_ST_RX_EMPTY]  = ctrl_reg.queue_mode_enable &&
                                         !flags_next.rx_empty_flag &&
                                         flags_reg.rx_empty_flag;
      end
   end

   sfs_irq u_irq (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .event_i   (irq_events),
      .clr_we_i  (wr_take && sel_istat),
      .mask_we_i (wr_take && sel_imask),
      .wdata_i   (wb_dat_i[3:0]),
      .stat_o    (irq_stat),
      .mask_o    (irq_mask),
      .irq_o     (irq_level)
   );

   // Pulses toward the FIFO storage, and the interrupt level
   assign rx_pop_o     = rx_pop && !rx_occ.empty;
   assign fifo_flush_o = settings_flush && ce_i;
   assign irq_o        = irq_level;

endmodule

// ### rtl/sfs_defines.svh
// Offsets, field positions, reset values and thresholds of the FIFO flag block
`ifndef SFS_DEFINES_SVH
`define SFS_DEFINES_SVH

// Register byte offsets
`define SFS_OFF_CTRL        8'h00
`define SFS_OFF_STATUS      8'h04
`define SFS_OFF_IRQ_STAT    8'h08
`define SFS_OFF_IRQ_MASK    8'h0C

// Control register field positions
`define SFS_CTRL_ENABLE     0
`define SFS_CTRL_WIDE       1
`define SFS_CTRL_QUEUE      2
`define SFS_CTRL_TX_MARK    3
`define SFS_CTRL_RX_MARK    4
`define SFS_CTRL_TX_DMA     5
`define SFS_CTRL_RX_DMA     6

// Status register field positions
`define SFS_ST_RX_EMPTY     0
`define SFS_ST_TX_FULL      1
`define SFS_ST_TX_NEAR_E    2
`define SFS_ST_RX_NEAR_F    3

// Reset values
`define SFS_CTRL_RST        7'h00
`define SFS_FLAGS_RST       4'h0
`define SFS_IRQ_RST         4'h0

// FIFO depth in entries, per word width
`define SFS_CAP_BYTES       4'h8
`define SFS_CAP_WORDS       4'h4

// Thresholds in bits held
`define SFS_RX_NF_BITS_M0   8'h30
`define SFS_RX_NF_BITS_M1   8'h20
`define SFS_TX_NE_BITS_M0   8'h10
`define SFS_TX_NE_BITS_M1   8'h20
`define SFS_TX_FULL_BITS    8'h40

`endif

// ### rtl/sfs_pkg.sv
// Types shared by the FIFO flag block
package sfs_pkg;

   // Bus slave states, one-hot
   typedef enum logic [1:0] {
      SFS_BUS_IDLE = 2'b01,
      SFS_BUS_ACK  = 2'b10
   } sfs_bus_state_t;

   // Control register contents
   typedef struct packed {
      logic rx_dma_enable;
      logic tx_dma_enable;
      logic rx_watermark_select;
      logic tx_watermark_select;
      logic queue_mode_enable;
      logic word_width_select;
      logic module_enable;
   } sfs_ctrl_t;

   // Four FIFO flags in status order
   typedef struct packed {
      logic rx_nearly_full_flag;
      logic tx_nearly_empty_flag;
      logic tx_full_flag;
      logic rx_empty_flag;
   } sfs_flags_t;

endpackage

// ### rtl/sfs_occ_if.sv
// Occupancy carrier between flag logic and one entry counter
`timescale 1ns/1ns
interface sfs_occ_if;
   logic       push;
   logic       pop;
   logic       flush;
   logic       wide;
   logic [3:0] level;
   logic       full;
   logic       empty;

   modport ctl (output push, output pop, output flush, output wide,
                input level, input full, input empty);
   modport cnt (input push, input pop, input flush, input wide,
                output level, output full, output empty);
endinterface

// ### rtl/sfs_occ_count.sv
// Entry counter of one FIFO, depth set by word width
`timescale 1ns/1ns
`include "sfs_defines.svh"
module sfs_occ_count (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   // Occupancy
   sfs_occ_if.cnt    occ
);
   logic [3:0] level_reg;
   logic [3:0] cap;
   logic       do_push;
   logic       do_pop;

   // Capacity and accepted moves
   assign cap     = occ.wide ? `SFS_CAP_WORDS : `SFS_CAP_BYTES;
   assign do_push = occ.push && (level_reg != cap);
   assign do_pop  = occ.pop && (level_reg != 4'h0);

   // Entry count, flush wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_reg <= 4'h0;
      end else if (ce_i) begin
         if (occ.flush) begin
            level_reg <= 4'h0;
         end else if (do_push && !do_pop) begin
            level_reg <= level_reg + 4'h1;
         end else if (do_pop && !do_push) begin
            level_reg <= level_reg - 4'h1;
         end
      end
   end

   assign occ.level = level_reg;
   assign occ.full  = (level_reg == cap);
   assign occ.empty = (level_reg == 4'h0);
endmodule

// ### rtl/sfs_irq.sv
// Sticky event bits, mask and level interrupt
`timescale 1ns/1ns
`include "sfs_defines.svh"
module sfs_irq (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   // Events and software access
   input  wire logic [3:0] event_i,
   input  wire logic       clr_we_i,
   input  wire logic       mask_we_i,
   input  wire logic [3:0] wdata_i,
   // Results
   output logic      [3:0] stat_o,
   output logic      [3:0] mask_o,
   output logic            irq_o
);
   logic [3:0] stat_reg;
   logic [3:0] mask_reg;

   // Sticky status, write one clears, a new event wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_reg <= `SFS_IRQ_RST;
      end else if (ce_i) begin
         stat_reg <= (stat_reg & ~(clr_we_i ? wdata_i : 4'h0)) | event_i;
      end
   end

   // Mask register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_reg <= `SFS_IRQ_RST;
      end else if (ce_i && mask_we_i) begin
         mask_reg <= wdata_i;
      end
   end

   assign stat_o = stat_reg;
   assign mask_o = mask_reg;
   assign irq_o  = |(stat_reg & mask_reg);
endmodule

// ### bench/sfs_top_sva.sv
// Port checker of the FIFO flag block
`timescale 1ns/1ns
module sfs_top_sva
   import sfs_pkg::*;
(
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   // Wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Traffic and results
   input wire logic        tx_push_i,
   input wire logic        tx_pop_i,
   input wire logic        rx_push_i,
   input wire logic        data_high_read_i,
   input wire logic        data_low_read_i,
   input wire logic        rx_pop_o,
   input wire logic        fifo_flush_o,
   input wire sfs_flags_t  flags_o,
   input wire logic        tx_dma_req_o,
   input wire logic        rx_dma_req_o,
   input wire logic        irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Request held, then a single ack pulse
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ans;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_bus_answer: assert property (s_req |=> s_ans) else $error("bus ack missing or long");
   a_write_zero: assert property (s_req and wb_we_i |=> wb_dat_o == 32'h0)
      else $error("write returned data");
   a_reset_flags: assert property ($fell(rst_i) |-> flags_o == 4'h0 && !irq_o)
      else $error("flags not zero after reset");
   a_flush_reinit: assert property (fifo_flush_o |=> !flags_o.tx_full_flag
      && !flags_o.rx_nearly_full_flag
      && flags_o.tx_nearly_empty_flag == flags_o.rx_empty_flag) else $error("flush state");
   a_flush_write: assert property (fifo_flush_o |-> wb_cyc_i && wb_stb_i && wb_we_i
      && !wb_ack_o) else $error("flush without a taken write");
   a_pop_low: assert property (rx_pop_o |-> data_low_read_i)
      else $error("pop without low read");
   a_txdma_full: assert property (tx_dma_req_o |-> !flags_o.tx_full_flag)
      else $error("tx request while full");
   a_rxdma_data: assert property (rx_dma_req_o |-> !flags_o.rx_empty_flag)
      else $error("rx request while empty");
   a_full_near: assert property (flags_o.tx_full_flag |-> !flags_o.tx_nearly_empty_flag)
      else $error("full and nearly empty");
   a_empty_nf: assert property (flags_o.rx_empty_flag |-> !flags_o.rx_nearly_full_flag)
      else $error("empty and nearly full");
endmodule

bind sfs_top sfs_top_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .tx_push_i(tx_push_i), .tx_pop_i(tx_pop_i), .rx_push_i(rx_push_i),
   .data_high_read_i(data_high_read_i), .data_low_read_i(data_low_read_i),
   .rx_pop_o(rx_pop_o), .fifo_flush_o(fifo_flush_o), .flags_o(flags_o),
   .tx_dma_req_o(tx_dma_req_o), .rx_dma_req_o(rx_dma_req_o), .irq_o(irq_o));

// ### bench/sfs_dma_model.sv
// DMA partner: fills transmit and drains receive on request
`timescale 1ns/1ns
module sfs_dma_model (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Control and requests
   input  wire logic go_i,
   input  wire logic tx_req_i,
   input  wire logic rx_req_i,
   // Transfers
   output logic      tx_push_o,
   output logic      read_o
);
   logic [1:0] phase_reg;
   // One transfer each way every fourth cycle so requests can settle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_reg <= 2'h0;
         tx_push_o <= 1'b0;
         read_o    <= 1'b0;
      end else begin
         phase_reg <= phase_reg + 2'h1;
         tx_push_o <= go_i && phase_reg == 2'h0 && tx_req_i;
         read_o    <= go_i && phase_reg == 2'h0 && rx_req_i;
      end
   end
endmodule

// ### bench/tb.sv
// Random and corner-case bench of the FIFO flag block
`timescale 1ns/1ns
`include "sfs_defines.svh"
module tb;
   import sfs_pkg::*;
   logic        clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, rx_pop, flush;
   logic        go, m_push, m_rd, tx_req, rx_req, irq, ce;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat, wb_rdat, rd;
   logic [4:0]  tr;
   logic [2:0]  cfg;
   sfs_flags_t  flags, ef;
   int          err_total, check_count, seed, tn, rn, k, cap;
   int          nflush = 0;

   sfs_top dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .tx_push_i(tr[0] | m_push), .tx_pop_i(tr[1]),
      .rx_push_i(tr[2]), .data_high_read_i(tr[3] | m_rd), .data_low_read_i(tr[4] | m_rd),
      .rx_pop_o(rx_pop), .fifo_flush_o(flush), .flags_o(flags), .tx_dma_req_o(tx_req),
      .rx_dma_req_o(rx_req), .irq_o(irq));
   sfs_dma_model dma (.clk_i(clk), .rst_i(rst), .go_i(go), .tx_req_i(tx_req),
      .rx_req_i(rx_req), .tx_push_o(m_push), .read_o(m_rd));

   // Clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Settings flushes seen by the bench
   always @(posedge clk) begin
      if (flush === 1'b1) nflush <= nflush + 1;
   end

   // Expected flags from occupancy in entries
   function automatic sfs_flags_t exp_flags(input logic w, tm, rm, input int t, r);
      sfs_flags_t f;
      int         b;
      b = w ? 16 : 8;
      f.rx_nearly_full_flag  = r * b >= (rm ? 32 : 48);
      f.tx_nearly_empty_flag = t * b <= (tm ? 32 : 16);
      f.tx_full_flag         = t * b >= 64;
      f.rx_empty_flag        = r == 0;
      return f;
   endfunction

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      chk_word(nm, {31'h0, e}, {31'h0, g});
   endtask

   // One classic Wishbone cycle, held until ack
   task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_sel <= 4'hF;
      wb_we  <= we;
      wb_adr <= a;
      wb_dat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (n >= 50) begin
         err_total++;
         complete_run();
      end
      @(posedge clk);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
      wb_cycle(1'b0, a, 32'h0);
      chk_word(nm, e, rd);
   endtask

   // Traffic pulses, then let flags and events land
   task automatic pulse(input int n, input logic [4:0] m);
      repeat (n) begin
         tr <= m;
         @(posedge clk);
      end
      tr <= 5'h0;
      repeat (4) @(posedge clk);
   endtask

   initial begin
      {rst, wb_cyc, wb_stb, wb_we, go} = 5'h10;
      {wb_adr, wb_dat, tr} = 45'h0;
      wb_sel = 4'hF;
      ce = 1'b1;
      {err_total, check_count, seed} = {32'h0, 32'h0, 32'd90953};
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rdc(`SFS_OFF_CTRL, 32'h0, "ctrl reset");
      rdc(`SFS_OFF_STATUS, 32'h0, "status reset");
      rdc(8'h40, 32'h0, "unmapped");
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         cfg = i[2:0];
         cap = cfg[0] ? 4 : 8;
         wb_cycle(1'b1, `SFS_OFF_CTRL, 32'h0);
         wb_cycle(1'b1, `SFS_OFF_CTRL, {27'h0, cfg[2], cfg[1], 1'b1, cfg[0], 1'b1});
         ef = exp_flags(cfg[0], cfg[1], cfg[2], 0, 0);
         rdc(`SFS_OFF_STATUS, {28'h0, ef}, "status after flush");
         tn = $unsigned($random(seed)) % (cap + 2);
         rn = $unsigned($random(seed)) % (cap + 2);
         k = $unsigned($random(seed)) % 3;
         pulse(tn, 5'h01);
         pulse(k, 5'h02);
         pulse(rn, 5'h04);
         tn = (tn > cap ? cap : tn) - k;
         tn = tn < 0 ? 0 : tn;
         rn = rn > cap ? cap : rn;
         ef = exp_flags(cfg[0], cfg[1], cfg[2], tn, rn);
         rdc(`SFS_OFF_STATUS, {28'h0, ef}, "status levels");
         chk_word("flags port", {28'h0, ef}, {28'h0, flags});
         wb_cycle(1'b1, `SFS_OFF_STATUS, 32'hF);
         rdc(`SFS_OFF_STATUS, {28'h0, ef}, "status after write");
         if (rn > 0) begin
            tr <= 5'h10;
            #1 chk_bit("pop on low read", !cfg[0], rx_pop);
            @(posedge clk);
            rn = rn - (cfg[0] ? 0 : 1);
         end
         pulse(rn, 5'h18);
         ef = exp_flags(cfg[0], cfg[1], cfg[2], tn, 0);
         chk_word("drained", {28'h0, ef}, {28'h0, flags});
         $display("test config %0d done", i);
      end
      wb_cycle(1'b1, `SFS_OFF_CTRL, 32'h1);
      pulse(3, 5'h05);
      rdc(`SFS_OFF_STATUS, 32'h0, "status queue off");
      $display("test queue off done");
      wb_cycle(1'b1, `SFS_OFF_CTRL, 32'h65);
      pulse(5, 5'h04);
      chk_bit("tx request", 1'b1, tx_req);
      chk_bit("rx request", 1'b1, rx_req);
      go <= 1'b1;
      k = 0;
      while (!(flags.tx_full_flag === 1'b1 && flags.rx_empty_flag === 1'b1) && k < 300) begin
         @(posedge clk);
         k++;
      end
      go <= 1'b0;
      chk_bit("dma finished", 1'b1, k < 300);
      if (k >= 300) complete_run();
      pulse(0, 5'h0);
      chk_bit("tx request idle", 1'b0, tx_req);
      chk_bit("rx request idle", 1'b0, rx_req);
      $display("test dma done");
      ce <= 1'b0;
      pulse(2, 5'h04);
      ce <= 1'b1;
      pulse(0, 5'h0);
      ef = exp_flags(1'b0, 1'b0, 1'b0, 8, 0);
      chk_word("flags frozen", {28'h0, ef}, {28'h0, flags});
      $display("test clock enable done");
      wb_cycle(1'b1, `SFS_OFF_IRQ_MASK, 32'h1);
      wb_cycle(1'b1, `SFS_OFF_IRQ_STAT, 32'hF);
      rdc(`SFS_OFF_IRQ_MASK, 32'h1, "irq mask");
      rdc(`SFS_OFF_IRQ_STAT, 32'h0, "irq cleared");
      pulse(1, 5'h04);
      chk_bit("irq raised", 1'b1, irq);
      wb_cycle(1'b1, `SFS_OFF_IRQ_MASK, 32'h0);
      chk_bit("irq masked", 1'b0, irq);
      wb_cycle(1'b1, `SFS_OFF_IRQ_STAT, 32'h1);
      rdc(`SFS_OFF_IRQ_STAT, 32'h0, "irq stat cleared");
      $display("test irq done");
      chk_word("flush count", 32'd17, nflush);
      complete_run();
   end
endmodule
